//--- rtl/kbd_port_pkg.sv
// constants and carrier types for the keyboard host port block
// assumes a 200 MHz block clock and byte-wide host and cpu buses
`default_nettype none
package kbd_port_pkg;
  localparam int          CLK_MHZ          = 200;
  localparam int          RST_DELAY_US     = 14;
  localparam int          RST_WIDTH_US     = 6;
  localparam int          RST_DELAY_CYC    = RST_DELAY_US * CLK_MHZ;
  localparam int          RST_WIDTH_CYC    = RST_WIDTH_US * CLK_MHZ;
  localparam int          CNT_W            = 13;
  localparam logic [15:0] ADDR_DATA        = 16'h0060;
  localparam logic [15:0] ADDR_CMD         = 16'h0064;
  localparam logic [15:0] ADDR_FAST        = 16'h0092;
  localparam logic [7:0]  CMD_PULSE_RESET  = 8'hFE;
  localparam logic [7:0]  STATUS_RESET     = 8'h00;
  localparam logic [7:0]  FAST_READ_CONST  = 8'h24;
  localparam logic [7:0]  CFG_RESET        = 8'h00;
  localparam int          ST_OUTF          = 0;
  localparam int          ST_INF           = 1;
  localparam int          ST_CD            = 3;
  localparam int          FAST_A20_BIT     = 1;
  localparam int          FAST_RST_BIT     = 0;
  localparam int          CFG_FAST_EN      = 2;
  localparam int          CFG_A20_HW       = 1;
  localparam int          CFG_RST_HW       = 0;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  data;
  } host_req_t;

  typedef struct packed {
    logic        data_rd;
    logic        data_wr;
    logic        status_wr;
    logic [7:0]  data;
  } cpu_req_t;

  typedef enum logic [1:0] {P_IDLE, P_DELAY, P_LOW, P_DONE} pulse_st_t;
endpackage
`default_nettype wire

//--- rtl/reset_pulse_gen.sv
// delayed, timed low-going reset pulse generator
// assumes start is a one-cycle request; one pulse per request
`default_nettype none
module reset_pulse_gen (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic start_in,
  input  wire logic rearm_in,
  output logic      pulse_n_out
);
  kbd_port_pkg::pulse_st_t                st_reg, st_next;
  logic [kbd_port_pkg::CNT_W-1:0]         cnt_reg, cnt_next;
  logic                                   out_reg, out_next;

  localparam logic [kbd_port_pkg::CNT_W-1:0] DLY_LAST =
    kbd_port_pkg::CNT_W'(kbd_port_pkg::RST_DELAY_CYC - 1);
  localparam logic [kbd_port_pkg::CNT_W-1:0] WID_LAST =
    kbd_port_pkg::CNT_W'(kbd_port_pkg::RST_WIDTH_CYC - 1);

  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    out_next = 1'b1;
    unique case (st_reg)
      kbd_port_pkg::P_IDLE: begin
        if (start_in) begin
          st_next  = kbd_port_pkg::P_DELAY;
          cnt_next = '0;
        end
      end
      kbd_port_pkg::P_DELAY: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == DLY_LAST) begin
          st_next  = kbd_port_pkg::P_LOW;
          cnt_next = '0;
          out_next = 1'b0;
        end
      end
      kbd_port_pkg::P_LOW: begin
        out_next = 1'b0;
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == WID_LAST) begin
          st_next  = kbd_port_pkg::P_DONE;
          out_next = 1'b1;
        end
      end
      kbd_port_pkg::P_DONE: begin
        // no second pulse until rearmed
        if (rearm_in) begin
          st_next = kbd_port_pkg::P_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg  <= kbd_port_pkg::P_IDLE;
      cnt_reg <= '0;
      out_reg <= 1'b1;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign pulse_n_out = out_reg;
endmodule
`default_nettype wire

//--- rtl/kbd_host_port_fast_reset_a20.sv
// keyboard host mailbox with fast a20 and cpu reset register
// assumes host and cpu strobes are one-cycle, synchronous to SYS_CLK_IN
//
// Notes on behaviour
// - cpu data write fills host buffer, sets output full
// - cpu data read returns host byte, clears input full
// - status: out full d0, in full d1, cmd/data d3
// - status clears to zero on reset
// - host reads status; cpu writes user bits
// - host write sets cmd/data from sa2
// - host write sets input full, raises cpu interrupt
// - cpu read clears input full and interrupt
// - host read of data clears output full
// - only external reset pin resets block
// - fast register works only when enabled
// - fast register reserved bits read constants
// - bit 1 write sets alternate a20 level
// - bit 0 one: 14us wait, 6us low
// - no new pulse until bit 0 cleared
// - reset clears bit 0, pulse inactive high
// - hardware mode pulses reset on command fe
// - both pulses anded, polarity selectable
// - config bits: fast enable, a20 hw, reset hw
// - host ports 60 data, 64 command/status
// - cpu a20 mask is or of sources
`default_nettype none
module kbd_host_port_fast_reset_a20 (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RSTN_IN,
  input  wire logic        HOST_RD_IN,
  input  wire logic        HOST_WR_IN,
  input  wire logic [15:0] HOST_ADDR_IN,
  input  wire logic [7:0]  HOST_DATA_IN,
  output logic      [7:0]  HOST_DATA_OUT,
  output logic             HOST_DATA_OE_OUT,
  input  wire logic        CPU_DATA_RD_IN,
  input  wire logic        CPU_DATA_WR_IN,
  input  wire logic        CPU_STATUS_WR_IN,
  input  wire logic [7:0]  CPU_DATA_IN,
  output logic      [7:0]  CPU_DATA_OUT,
  output logic      [7:0]  CPU_STATUS_OUT,
  input  wire logic        KBD_IRQ_EN_IN,
  input  wire logic        CPU_IRQ_EN_IN,
  input  wire logic        CFG_WR_IN,
  input  wire logic [7:0]  CFG_DATA_IN,
  output logic      [7:0]  CFG_DATA_OUT,
  input  wire logic        FIRMWARE_A20_PORT_BIT_IN,
  input  wire logic        FIRMWARE_RESET_SIGNAL_IN,
  input  wire logic        KBD_RESET_INVERT_IN,
  output logic             KEYBOARD_INTERRUPT_OUT,
  output logic             CPU_INPUT_INTERRUPT_OUT,
  output logic             ALTERNATE_A20_LEVEL_OUT,
  output logic             ALTERNATE_RESET_PULSE_OUT,
  output logic             CPU_A20_MASK_OUT,
  output logic             KEYBOARD_RESET_OUT
);
  kbd_port_pkg::host_req_t host;
  kbd_port_pkg::cpu_req_t  cpu;

  logic [7:0] status_reg,   status_next;
  logic [7:0] to_host_reg,  to_host_next;
  logic [7:0] to_cpu_reg,   to_cpu_next;
  logic [7:0] cfg_reg,      cfg_next;
  logic [1:0] fast_reg,     fast_next;
  logic [7:0] hdata_reg,    hdata_next;
  logic       hoe_reg,      hoe_next;
  logic [7:0] cdata_reg,    cdata_next;
  logic       kbd_irq_reg,  kbd_irq_next;
  logic       cirq_reg,     cirq_next;
  logic       a20m_reg,     a20m_next;
  logic       krst_reg,     krst_next;
  logic       alt_rst_reg,  alt_rst_next;

  logic       fast_en;
  logic       h_wr_data;
  logic       h_wr_cmd;
  logic       h_rd_data;
  logic       h_rd_stat;
  logic       h_wr_fast;
  logic       h_rd_fast;
  logic       fast_start;
  logic       fast_rearm;
  logic       cmd_start;
  logic       fast_pulse_n;
  logic       cmd_pulse_n;
  logic       merged_n;

  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] target);
    hit = (a == target);
  endfunction

  assign host = '{rd: HOST_RD_IN, wr: HOST_WR_IN,
                  addr: HOST_ADDR_IN, data: HOST_DATA_IN};
  assign cpu  = '{data_rd: CPU_DATA_RD_IN, data_wr: CPU_DATA_WR_IN,
                  status_wr: CPU_STATUS_WR_IN, data: CPU_DATA_IN};

  assign fast_en   = cfg_reg[kbd_port_pkg::CFG_FAST_EN];
  assign h_wr_data = host.wr && hit(host.addr, kbd_port_pkg::ADDR_DATA);
  assign h_wr_cmd  = host.wr && hit(host.addr, kbd_port_pkg::ADDR_CMD);
  assign h_rd_data = host.rd && hit(host.addr, kbd_port_pkg::ADDR_DATA);
  assign h_rd_stat = host.rd && hit(host.addr, kbd_port_pkg::ADDR_CMD);
  assign h_wr_fast = host.wr && fast_en &&
                     hit(host.addr, kbd_port_pkg::ADDR_FAST);
  assign h_rd_fast = host.rd && fast_en &&
                     hit(host.addr, kbd_port_pkg::ADDR_FAST);

  // edge of bit 0 from 0 to 1 starts the pulse
  assign fast_start = h_wr_fast && host.data[kbd_port_pkg::FAST_RST_BIT] &&
                      !fast_reg[kbd_port_pkg::FAST_RST_BIT];
  assign fast_rearm = !fast_reg[kbd_port_pkg::FAST_RST_BIT];
  assign cmd_start  = h_wr_cmd && cfg_reg[kbd_port_pkg::CFG_RST_HW] &&
                      (host.data == kbd_port_pkg::CMD_PULSE_RESET);

  reset_pulse_gen fast_gen (
    .clk_in      (SYS_CLK_IN),
    .rstn_in     (RSTN_IN),
    .start_in    (fast_start),
    .rearm_in    (fast_rearm),
    .pulse_n_out (fast_pulse_n)
  );

  // command pulse rearms itself once finished
  reset_pulse_gen cmd_gen (
    .clk_in      (SYS_CLK_IN),
    .rstn_in     (RSTN_IN),
    .start_in    (cmd_start),
    .rearm_in    (1'b1),
    .pulse_n_out (cmd_pulse_n)
  );

  always_comb begin
    status_next  = status_reg;
    to_host_next = to_host_reg;
    to_cpu_next  = to_cpu_reg;
    cfg_next     = cfg_reg;
    fast_next    = fast_reg;
    if (cpu.status_wr) begin
      status_next = cpu.data;
      status_next[kbd_port_pkg::ST_OUTF] = status_reg[kbd_port_pkg::ST_OUTF];
      status_next[kbd_port_pkg::ST_INF] = status_reg[kbd_port_pkg::ST_INF];
      status_next[kbd_port_pkg::ST_CD]  = status_reg[kbd_port_pkg::ST_CD];
    end
    if (h_rd_data) begin
      status_next[kbd_port_pkg::ST_OUTF] = 1'b0;
    end
    if (cpu.data_wr) begin
      to_host_next = cpu.data;
      status_next[kbd_port_pkg::ST_OUTF] = 1'b1;
    end
    if (cpu.data_rd) begin
      status_next[kbd_port_pkg::ST_INF] = 1'b0;
    end
    // hardware command byte is still handed to firmware
    if (h_wr_data || h_wr_cmd) begin
      to_cpu_next = host.data;
      status_next[kbd_port_pkg::ST_INF] = 1'b1;
      status_next[kbd_port_pkg::ST_CD]  = h_wr_cmd;
    end
    if (CFG_WR_IN) begin
      cfg_next = {5'h00, CFG_DATA_IN[2:0]};
    end
    if (h_wr_fast) begin
      fast_next = host.data[1:0];
    end
  end

  assign merged_n = fast_en ? (fast_pulse_n & cmd_pulse_n)
                            : cmd_pulse_n;

  always_comb begin
    hdata_next   = hdata_reg;
    hoe_next     = host.rd && (h_rd_data || h_rd_stat || h_rd_fast);
    if (h_rd_data) begin
      hdata_next = to_host_reg;
    end else if (h_rd_stat) begin
      hdata_next = status_reg;
    end else if (h_rd_fast) begin
      hdata_next = kbd_port_pkg::FAST_READ_CONST | {6'h00, fast_reg};
    end
    cdata_next   = to_cpu_reg;
    kbd_irq_next = KBD_IRQ_EN_IN && status_next[kbd_port_pkg::ST_OUTF];
    cirq_next    = CPU_IRQ_EN_IN && status_next[kbd_port_pkg::ST_INF];
    a20m_next    = FIRMWARE_A20_PORT_BIT_IN |
                   (fast_en & fast_next[kbd_port_pkg::FAST_A20_BIT]);
    alt_rst_next = fast_pulse_n;
    krst_next    = (cfg_reg[kbd_port_pkg::CFG_RST_HW] ? merged_n
                   : (merged_n & FIRMWARE_RESET_SIGNAL_IN))
                   ^ KBD_RESET_INVERT_IN;
  end

  // single async reset pin for everything
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      status_reg  <= kbd_port_pkg::STATUS_RESET;
      to_host_reg <= 8'h00;
      to_cpu_reg  <= 8'h00;
      cfg_reg     <= kbd_port_pkg::CFG_RESET;
      fast_reg    <= 2'h0;
      hdata_reg   <= 8'h00;
      hoe_reg     <= 1'b0;
      cdata_reg   <= 8'h00;
      kbd_irq_reg <= 1'b0;
      cirq_reg    <= 1'b0;
      a20m_reg    <= 1'b0;
      krst_reg    <= 1'b1;
      alt_rst_reg <= 1'b1;
    end else begin
      status_reg  <= status_next;
      to_host_reg <= to_host_next;
      to_cpu_reg  <= to_cpu_next;
      cfg_reg     <= cfg_next;
      fast_reg    <= fast_next;
      hdata_reg   <= hdata_next;
      hoe_reg     <= hoe_next;
      cdata_reg   <= cdata_next;
      kbd_irq_reg <= kbd_irq_next;
      cirq_reg    <= cirq_next;
      a20m_reg    <= a20m_next;
      krst_reg    <= krst_next;
      alt_rst_reg <= alt_rst_next;
    end
  end

  assign HOST_DATA_OUT             = hdata_reg;
  assign HOST_DATA_OE_OUT          = hoe_reg;
  assign CPU_DATA_OUT              = cdata_reg;
  assign CPU_STATUS_OUT            = status_reg;
  assign CFG_DATA_OUT              = cfg_reg;
  assign KEYBOARD_INTERRUPT_OUT    = kbd_irq_reg;
  assign CPU_INPUT_INTERRUPT_OUT   = cirq_reg;
  assign ALTERNATE_A20_LEVEL_OUT   = fast_reg[kbd_port_pkg::FAST_A20_BIT];
  assign ALTERNATE_RESET_PULSE_OUT = alt_rst_reg;
  assign CPU_A20_MASK_OUT          = a20m_reg;
  assign KEYBOARD_RESET_OUT        = krst_reg;
endmodule
`default_nettype wire

//--- test/kbd_cpu_model.sv
// keyboard cpu model: answers the input interrupt by reading the byte
// assumes strobes sampled at SYS_CLK_IN rising edge
`default_nettype none
module kbd_cpu_model (
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       irq_in,
  input  wire logic       en_in,
  input  wire logic [7:0] lat_in,
  input  wire logic [7:0] data_in,
  output logic            rd_out,
  output logic      [7:0] got_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // lat_in 0 answers at once, larger values model a busy firmware
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_out <= 1'b0;
      got_out <= 8'h00;
      cnt <= -1;
    end else if (rd_out) begin
      rd_out <= 1'b0;
      got_out <= data_in;
      cnt <= -2;
    end else if (cnt == -2) begin
      cnt <= -1;
    end else if (cnt == -1) begin
      if (irq_in && en_in) begin
        cnt <= lat_in;
      end
    end else if (cnt == 0) begin
      rd_out <= 1'b1;
    end else begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

//--- test/kbd_port_checker.sv
// checker for the keyboard host port block
// assumes bind by name onto the top module's ports
`default_nettype none
module kbd_port_checker (
  input wire logic        SYS_CLK_IN,
  input wire logic        RSTN_IN,
  input wire logic        HOST_RD_IN,
  input wire logic        HOST_WR_IN,
  input wire logic [15:0] HOST_ADDR_IN,
  input wire logic [7:0]  HOST_DATA_IN,
  input wire logic [7:0]  HOST_DATA_OUT,
  input wire logic        HOST_DATA_OE_OUT,
  input wire logic        CPU_DATA_RD_IN,
  input wire logic        CPU_DATA_WR_IN,
  input wire logic [7:0]  CPU_STATUS_OUT,
  input wire logic        KBD_IRQ_EN_IN,
  input wire logic [7:0]  CFG_DATA_OUT,
  input wire logic        KEYBOARD_INTERRUPT_OUT,
  input wire logic        CPU_INPUT_INTERRUPT_OUT,
  input wire logic        ALTERNATE_RESET_PULSE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] AD = kbd_port_pkg::ADDR_DATA;
  localparam logic [15:0] AC = kbd_port_pkg::ADDR_CMD;
  localparam logic [15:0] AF = kbd_port_pkg::ADDR_FAST;
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  logic run_reg;
  logic arm_reg;
  int   since_reg;
  int   low_reg;
  wire logic fast_wr = HOST_WR_IN && HOST_ADDR_IN == AF && CFG_DATA_OUT[2];
  // mirrors bit 0 so a second write of one is known not to start a pulse
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      run_reg <= 1'b0;
      arm_reg <= 1'b0;
      since_reg <= 0;
      low_reg <= 0;
    end else begin
      if (fast_wr) begin
        arm_reg <= HOST_DATA_IN[0];
      end
      if (fast_wr && HOST_DATA_IN[0] && !arm_reg) begin
        run_reg <= 1'b1;
        since_reg <= 0;
      end else if (!ALTERNATE_RESET_PULSE_OUT) begin
        run_reg <= 1'b0;
      end else if (run_reg) begin
        since_reg <= since_reg + 1;
      end
      low_reg <= ALTERNATE_RESET_PULSE_OUT ? 0 : low_reg + 1;
    end
  end
  sequence s_rd(logic [15:0] a, logic c);
    HOST_RD_IN && HOST_ADDR_IN == a && c;
  endsequence
  chk_out_full_set: assert property (CPU_DATA_WR_IN ##1
    $stable(KBD_IRQ_EN_IN) |-> CPU_STATUS_OUT[0]
    && KEYBOARD_INTERRUPT_OUT == KBD_IRQ_EN_IN) else $error("full or irq");
  chk_cmd_write: assert property (HOST_WR_IN && HOST_ADDR_IN == AC
    |=> CPU_STATUS_OUT[1] && CPU_STATUS_OUT[3]) else $error("cmd write");
  chk_data_write: assert property (HOST_WR_IN && HOST_ADDR_IN == AD
    |=> CPU_STATUS_OUT[1] && !CPU_STATUS_OUT[3]) else $error("data write");
  chk_in_full_clear: assert property (CPU_DATA_RD_IN && !HOST_WR_IN
    |=> !CPU_STATUS_OUT[1] && !CPU_INPUT_INTERRUPT_OUT) else $error("in full");
  chk_out_full_clear: assert property (s_rd(AD, !CPU_DATA_WR_IN)
    |=> !CPU_STATUS_OUT[0] && HOST_DATA_OE_OUT) else $error("out full clear");
  chk_status_read: assert property (s_rd(AC, 1'b1) |=> HOST_DATA_OE_OUT
    && HOST_DATA_OUT == $past(CPU_STATUS_OUT)) else $error("status read");
  chk_fast_off: assert property (s_rd(AF, !CFG_DATA_OUT[2])
    |=> !HOST_DATA_OE_OUT) else $error("fast register answered");
  chk_fast_read: assert property (s_rd(AF, CFG_DATA_OUT[2])
    |=> HOST_DATA_OE_OUT && HOST_DATA_OUT[7:2] == 6'h09) else $error("fast");
  chk_pulse_delay: assert property ($fell(ALTERNATE_RESET_PULSE_OUT)
    |-> run_reg && since_reg inside {[2798:2808]}) else $error("delay");
  chk_pulse_width: assert property ($rose(ALTERNATE_RESET_PULSE_OUT)
    |-> low_reg inside {[1198:1202]}) else $error("pulse width");
endmodule
bind kbd_host_port_fast_reset_a20 kbd_port_checker kbd_port_checker_inst (.*);
`default_nettype wire

//--- test/kbd_host_port_fast_reset_a20_tb.sv
// bench for the keyboard host port block
// assumes the keyboard cpu model answers the input interrupt
`default_nettype none
module kbd_host_port_fast_reset_a20_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0]  op;
    logic [15:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
  } row_t;
  // signals carry the port names so the instance connects by name
  logic SYS_CLK_IN = 0, RSTN_IN = 0, HOST_RD_IN = 0, HOST_WR_IN = 0;
  logic CPU_DATA_WR_IN = 0, CPU_STATUS_WR_IN = 0, CFG_WR_IN = 0;
  logic KBD_IRQ_EN_IN = 1, CPU_IRQ_EN_IN = 1, KBD_RESET_INVERT_IN = 0;
  logic FIRMWARE_A20_PORT_BIT_IN = 0, FIRMWARE_RESET_SIGNAL_IN = 1;
  logic [15:0] HOST_ADDR_IN = 16'h0000;
  logic [7:0]  HOST_DATA_IN = 8'h00, CPU_DATA_IN = 8'h00, CFG_DATA_IN = 8'h00;
  logic        part_en = 1;
  logic [7:0]  part_lat = 8'h00;
  wire logic   CPU_DATA_RD_IN, HOST_DATA_OE_OUT, KEYBOARD_INTERRUPT_OUT;
  wire logic   CPU_INPUT_INTERRUPT_OUT, ALTERNATE_A20_LEVEL_OUT;
  wire logic   ALTERNATE_RESET_PULSE_OUT, CPU_A20_MASK_OUT, KEYBOARD_RESET_OUT;
  wire logic [7:0] HOST_DATA_OUT, CPU_DATA_OUT, CPU_STATUS_OUT, CFG_DATA_OUT;
  wire logic [7:0] got;
  int err_count = 0;
  int checks_done = 0;
  int n;
  row_t rows [10] = '{'{0, 16'h0064, 8'hA5, 8'h08},
    '{0, 16'h0060, 8'h5A, 8'h00},
    '{1, 16'h0001, 8'h3C, 8'h00}, '{1, 16'h0000, 8'hC7, 8'h00},
    '{2, 16'h0000, 8'hFF, 8'hF4}, '{2, 16'h0000, 8'h00, 8'h00},
    '{3, 16'h0000, 8'h00, 8'h00}, '{3, 16'h0000, 8'h01, 8'h01},
    '{3, 16'h0000, 8'h02, 8'h01}, '{3, 16'h0000, 8'h03, 8'h01}};
  kbd_host_port_fast_reset_a20 kbd_host_port_fast_reset_a20_inst (.*);
  kbd_cpu_model kbd_cpu_model_inst (.clk_in(SYS_CLK_IN), .rstn_in(RSTN_IN),
    .irq_in(CPU_INPUT_INTERRUPT_OUT), .en_in(part_en), .lat_in(part_lat),
    .data_in(CPU_DATA_OUT), .rd_out(CPU_DATA_RD_IN), .got_out(got));
  always #2.5 SYS_CLK_IN = ~SYS_CLK_IN;
  task automatic give_verdict();
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] ex,
                       input logic [7:0] sn);
    checks_done++;
    if (sn !== ex) begin
      $display("Error %s expected %h seen %h", nm, ex, sn);
      err_count++;
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge SYS_CLK_IN);
    #1;
  endtask
  task automatic host(input logic rd, input logic [15:0] a,
                      input logic [7:0] d);
    @(posedge SYS_CLK_IN);
    HOST_RD_IN <= rd;
    HOST_WR_IN <= !rd;
    HOST_ADDR_IN <= a;
    HOST_DATA_IN <= d;
    @(posedge SYS_CLK_IN);
    HOST_RD_IN <= 1'b0;
    HOST_WR_IN <= 1'b0;
    #1;
  endtask
  task automatic cpu(input logic st, input logic [7:0] d);
    @(posedge SYS_CLK_IN);
    CPU_STATUS_WR_IN <= st;
    CPU_DATA_WR_IN <= !st;
    CPU_DATA_IN <= d;
    @(posedge SYS_CLK_IN);
    CPU_STATUS_WR_IN <= 1'b0;
    CPU_DATA_WR_IN <= 1'b0;
    tick(1);
  endtask
  task automatic cfg(input logic [7:0] d);
    @(posedge SYS_CLK_IN);
    CFG_WR_IN <= 1'b1;
    CFG_DATA_IN <= d;
    @(posedge SYS_CLK_IN);
    CFG_WR_IN <= 1'b0;
    tick(1);
  endtask
  // cycles until the chosen reset output shows lvl, capped at 3000
  task automatic measure(input logic sel, input logic lvl, output int k);
    k = 0;
    while ((sel ? KEYBOARD_RESET_OUT : ALTERNATE_RESET_PULSE_OUT) !== lvl
           && k < 3000) begin
      tick(1);
      k++;
    end
  endtask
  initial begin
    repeat (300) @(posedge SYS_CLK_IN);
    check("alt reset idle", 8'h01, ALTERNATE_RESET_PULSE_OUT);
    check("kbd reset idle", 8'h01, KEYBOARD_RESET_OUT);
    check("status reset", kbd_port_pkg::STATUS_RESET, CPU_STATUS_OUT);
    RSTN_IN <= 1'b1;
    host(1, kbd_port_pkg::ADDR_FAST, 8'h00);
    check("fast oe off", 8'h00, HOST_DATA_OE_OUT);
    host(1, 16'h0070, 8'h00);
    check("unmapped oe", 8'h00, HOST_DATA_OE_OUT);
    host(1, kbd_port_pkg::ADDR_CMD, 8'h00);
    check("host status", 8'h00, HOST_DATA_OUT);
    cfg(8'h04);
    check("config", 8'h04, CFG_DATA_OUT);
    foreach (rows[i]) begin
      case (rows[i].op)
        0: begin
          part_lat <= 8'(i * 20);
          host(0, rows[i].a, rows[i].d);
          tick(40);
          check("cpu byte", rows[i].d, got);
          check("status cd", rows[i].e, CPU_STATUS_OUT);
        end
        1: begin
          @(posedge SYS_CLK_IN);
          KBD_IRQ_EN_IN <= rows[i].a[0];
          cpu(0, rows[i].d);
          check("kbd irq", rows[i].a[0], KEYBOARD_INTERRUPT_OUT);
          check("status out full", 8'h01, CPU_STATUS_OUT);
          host(1, kbd_port_pkg::ADDR_DATA, 8'h00);
          check("host data", rows[i].d, HOST_DATA_OUT);
          check("status read", rows[i].e, CPU_STATUS_OUT);
        end
        2: begin
          cpu(1, rows[i].d);
          check("user bits", rows[i].e, CPU_STATUS_OUT);
          host(1, kbd_port_pkg::ADDR_CMD, 8'h00);
          check("host status", rows[i].e, HOST_DATA_OUT);
        end
        default: begin
          @(posedge SYS_CLK_IN);
          FIRMWARE_A20_PORT_BIT_IN <= rows[i].d[1];
          host(0, kbd_port_pkg::ADDR_FAST, {6'h00, rows[i].d[0], 1'b0});
          tick(2);
          check("alternate_a20_level", rows[i].d[0], ALTERNATE_A20_LEVEL_OUT);
          check("a20 mask", rows[i].e, CPU_A20_MASK_OUT);
          host(1, kbd_port_pkg::ADDR_FAST, 8'h00);
          check("fast read", 8'h24 | {rows[i].d[0], 1'b0},
                HOST_DATA_OUT);
        end
      endcase
    end
    // firmware stalls: flag stands until it reads, interrupt drops once masked
    part_en <= 1'b0;
    host(0, kbd_port_pkg::ADDR_DATA, 8'hC3);
    check("cpu irq", 8'h01, CPU_INPUT_INTERRUPT_OUT);
    @(posedge SYS_CLK_IN);
    CPU_IRQ_EN_IN <= 1'b0;
    tick(2);
    check("cpu irq masked", 8'h00, CPU_INPUT_INTERRUPT_OUT);
    check("in full held", 8'h02, CPU_STATUS_OUT);
    // firmware latency of 20 still applies, so wait well past it
    @(posedge SYS_CLK_IN);
    CPU_IRQ_EN_IN <= 1'b1;
    part_en <= 1'b1;
    tick(30);
    check("late byte", 8'hC3, got);
    host(0, kbd_port_pkg::ADDR_FAST, 8'h01);
    measure(0, 0, n);
    check("pulse delay", 8'h01, 8'(n >= 2795 && n <= 2810));
    tick(2);
    check("merged reset", 8'h00, KEYBOARD_RESET_OUT);
    measure(0, 1, n);
    check("pulse width", 8'h01, 8'(n >= 1195 && n <= 1205));
    host(0, kbd_port_pkg::ADDR_FAST, 8'h01);
    measure(0, 0, n);
    check("no second pulse", 8'h01, 8'(n == 3000));
    host(0, kbd_port_pkg::ADDR_FAST, 8'h00);
    host(0, kbd_port_pkg::ADDR_FAST, 8'h01);
    measure(0, 0, n);
    check("rearmed pulse", 8'h01, 8'(n < 3000));
    measure(0, 1, n);
    @(posedge SYS_CLK_IN);
    KBD_RESET_INVERT_IN <= 1'b1;
    tick(2);
    check("reset inverted", 8'h00, KEYBOARD_RESET_OUT);
    @(posedge SYS_CLK_IN);
    KBD_RESET_INVERT_IN <= 1'b0;
    cfg(8'h05);
    host(0, kbd_port_pkg::ADDR_CMD, kbd_port_pkg::CMD_PULSE_RESET);
    measure(1, 0, n);
    check("command pulse", 8'h01, 8'(n >= 2795 && n <= 2810));
    check("alt untouched", 8'h01, ALTERNATE_RESET_PULSE_OUT);
    measure(1, 1, n);
    cfg(8'h04);
    @(posedge SYS_CLK_IN);
    FIRMWARE_RESET_SIGNAL_IN <= 1'b0;
    tick(2);
    check("firmware reset", 8'h00, KEYBOARD_RESET_OUT);
    @(posedge SYS_CLK_IN);
    RSTN_IN <= 1'b0;
    tick(300);
    check("config reset", kbd_port_pkg::CFG_RESET, CFG_DATA_OUT);
    check("status reset", 8'h00, CPU_STATUS_OUT);
    give_verdict();
  end
  initial begin
    repeat (40000) @(posedge SYS_CLK_IN);
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
